// *** pmcb_consts.vh ***
`ifndef PMCB_CONSTS_VH
`define PMCB_CONSTS_VH

// register map: byte addresses of the seven pad registers
`define PMCB_ADDR_P0_11   32'h50020644
`define PMCB_ADDR_P0_12   32'h50020648
`define PMCB_ADDR_P0_13   32'h5002064c
`define PMCB_ADDR_P0_14   32'h50020650
`define PMCB_ADDR_P0_15   32'h50020654
`define PMCB_ADDR_P1_00   32'h50020658
`define PMCB_ADDR_P1_01   32'h5002065c
`define PMCB_ADDR_BASE    32'h50020644
`define PMCB_ADDR_LAST    32'h5002065c
`define PMCB_NUM_PADS     7
`define PMCB_IDX_W        3

// field layout
`define PMCB_REG_W        11
`define PMCB_DRV_BIT      10
`define PMCB_DP_HI        9
`define PMCB_DP_LO        8
`define PMCB_FN_HI        5
`define PMCB_FN_LO        0
`define PMCB_FN_W         6

// reset values
`define PMCB_DRV_RST      1'h0
`define PMCB_DP_RST       2'h2
`define PMCB_FN_RST       6'h00

// direction and pull codes
`define PMCB_DP_IN_NONE   2'h0
`define PMCB_DP_IN_UP     2'h1
`define PMCB_DP_IN_DOWN   2'h2
`define PMCB_DP_OUT       2'h3

`endif

// *** pmcb_regmem.v ***
`include "pmcb_consts.vh"

// small register store with one write port and a registered read port
module pmcb_regmem #(
  parameter DEPTH = `PMCB_NUM_PADS,
  parameter AW    = `PMCB_IDX_W,
  parameter DW    = `PMCB_REG_W
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // write port
  input  wire          wr_en,
  input  wire [AW-1:0] wr_idx,
  input  wire [DW-1:0] wr_data,
  // read port
  input  wire [AW-1:0] rd_idx,
  output reg  [DW-1:0] rd_data_r,
  // all entries flattened for the pad decode
  output wire [DEPTH*DW-1:0] all_flat
);

  reg [DW-1:0] mem_r [0:DEPTH-1];
  genvar g;

  // per-entry storage; reset gives pull-down input, push-pull, function 0
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : g_ent
      always @(posedge clk)
      begin
        if (rst)
          mem_r[g] <= {`PMCB_DRV_RST, `PMCB_DP_RST, 2'h0, `PMCB_FN_RST};
        else if (wr_en && wr_idx == g)
          mem_r[g] <= wr_data;
      end
      assign all_flat[g*DW +: DW] = mem_r[g];
    end
  endgenerate

  // registered read; out-of-range index reads zero
  always @(posedge clk)
  begin
    if (rst)
      rd_data_r <= {DW{1'b0}};
    else if (rd_idx < DEPTH)
      rd_data_r <= mem_r[rd_idx];
    else
      rd_data_r <= {DW{1'b0}};
  end

endmodule // pmcb_regmem

// *** pmcb_bank.v ***
// Notes on behaviour
// - code 00: input, no pull resistor
// - code 01: input with pull-up
// - code 10: input with pull-down, reset value
// - code 11: output, no pull resistor
// - analog mode ignores direction and pull field
//
// Our own choice: the address-and-strobe port.
`include "pmcb_consts.vh"

module pmcb_bank #(
  parameter NPAD = `PMCB_NUM_PADS
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst,
  // register port
  input  wire [31:0]       addr,
  input  wire [31:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output wire [31:0]       rdata_r,
  // analog mode per pad, from the converter
  input  wire [NPAD-1:0]   analog_mode,
  // pad controls
  output reg  [NPAD-1:0]   pad_out_en_r,
  output reg  [NPAD-1:0]   pad_in_en_r,
  output reg  [NPAD-1:0]   pad_pull_up_r,
  output reg  [NPAD-1:0]   pad_pull_down_r,
  output reg  [NPAD-1:0]   pad_open_drain_r,
  output reg  [NPAD*`PMCB_FN_W-1:0] pad_func_r
);

  localparam RW = `PMCB_REG_W;

  // word index of an address, valid flag in the top bit
  function [`PMCB_IDX_W:0] addr_dec;
    input [31:0] a;
    reg   [31:0] off;
    begin
      off = a - `PMCB_ADDR_BASE;
      if (a >= `PMCB_ADDR_BASE && a <= `PMCB_ADDR_LAST && a[1:0] == 2'h0)
        addr_dec = {1'b1, off[`PMCB_IDX_W+1:2]};
      else
        addr_dec = {1'b0, {`PMCB_IDX_W{1'b0}}};
    end
  endfunction

  wire [`PMCB_IDX_W:0] wr_dec = addr_dec(addr);
  wire                 wr_hit = wr & wr_dec[`PMCB_IDX_W];
  wire [RW-1:0]        wr_val;
  wire [RW-1:0]        rd_val;
  wire [NPAD*RW-1:0]   regs;
  wire [`PMCB_IDX_W-1:0] rd_sel;

  // no read hit steers the read port to an unused index, which reads zero;
  // keeps rdata_r a plain flop output, but NPAD must stay below 2**IDX_W
  assign rd_sel = (rd & wr_dec[`PMCB_IDX_W]) ? wr_dec[`PMCB_IDX_W-1:0] :
                  {`PMCB_IDX_W{1'b1}};

  // reserved bits 7:6 never stored, so they read zero
  assign wr_val = {wdata[`PMCB_DRV_BIT], wdata[`PMCB_DP_HI:`PMCB_DP_LO],
                   2'h0, wdata[`PMCB_FN_HI:`PMCB_FN_LO]};

  pmcb_regmem #(
    .DEPTH (NPAD),
    .AW    (`PMCB_IDX_W),
    .DW    (RW)
  ) u_mem (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr_hit),
    .wr_idx    (wr_dec[`PMCB_IDX_W-1:0]),
    .wr_data   (wr_val),
    .rd_idx    (rd_sel),
    .rd_data_r (rd_val),
    .all_flat  (regs)
  );

  // read data stand only in the cycle after the strobe, zero otherwise
  assign rdata_r = {{(32-RW){1'b0}}, rd_val};

  // per-pad decode of the direction and pull field, outputs registered
  genvar p;
  generate
    for (p = 0; p < NPAD; p = p + 1)
    begin : g_pad
      wire [1:0] dp  = regs[p*RW+`PMCB_DP_LO +: 2];
      wire       drv = regs[p*RW+`PMCB_DRV_BIT];
      always @(posedge clk)
      begin
        if (rst)
        begin
          pad_out_en_r[p]     <= 1'b0;
          pad_in_en_r[p]      <= 1'b1;
          pad_pull_up_r[p]    <= 1'b0;
          pad_pull_down_r[p]  <= 1'b1;
          pad_open_drain_r[p] <= `PMCB_DRV_RST;
          pad_func_r[p*`PMCB_FN_W +: `PMCB_FN_W] <= `PMCB_FN_RST;
        end
        else
        begin
          pad_func_r[p*`PMCB_FN_W +: `PMCB_FN_W] <=
            regs[p*RW+`PMCB_FN_LO +: `PMCB_FN_W];
          pad_open_drain_r[p] <= drv;
          if (analog_mode[p])
          begin
            // analog pad: digital buffers and pulls off
            pad_out_en_r[p]    <= 1'b0;
            pad_in_en_r[p]     <= 1'b0;
            pad_pull_up_r[p]   <= 1'b0;
            pad_pull_down_r[p] <= 1'b0;
          end
          else
          begin
            case (dp)
              `PMCB_DP_IN_NONE:
              begin
                pad_out_en_r[p]    <= 1'b0;
                pad_in_en_r[p]     <= 1'b1;
                pad_pull_up_r[p]   <= 1'b0;
                pad_pull_down_r[p] <= 1'b0;
              end
              `PMCB_DP_IN_UP:
              begin
                pad_out_en_r[p]    <= 1'b0;
                pad_in_en_r[p]     <= 1'b1;
                pad_pull_up_r[p]   <= 1'b1;
                pad_pull_down_r[p] <= 1'b0;
              end
              `PMCB_DP_IN_DOWN:
              begin
                pad_out_en_r[p]    <= 1'b0;
                pad_in_en_r[p]     <= 1'b1;
                pad_pull_up_r[p]   <= 1'b0;
                pad_pull_down_r[p] <= 1'b1;
              end
              default:
              begin
                pad_out_en_r[p]    <= 1'b1;
                pad_in_en_r[p]     <= 1'b0;
                pad_pull_up_r[p]   <= 1'b0;
                pad_pull_down_r[p] <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  endgenerate

endmodule // pmcb_bank

// *** pmcb_bank_assertions.sv ***
module pmcb_chk #(
  parameter NPAD = 7
) (
  // clock, reset, bus
  input wire              clk,
  input wire              rst,
  input wire [31:0]       addr,
  input wire [31:0]       wdata,
  input wire              wr,
  input wire [31:0]       rdata_r,
  // pad side
  input wire [NPAD-1:0]   analog_mode,
  input wire [NPAD-1:0]   pad_out_en_r,
  input wire [NPAD-1:0]   pad_pull_up_r,
  input wire [NPAD-1:0]   pad_pull_down_r,
  input wire [NPAD-1:0]   pad_open_drain_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // either pull enable
  wire [NPAD-1:0] pulls = pad_pull_up_r | pad_pull_down_r;
  // pad 0 write, then a quiet cycle so the decode is not overtaken
  sequence s_wr0;
    wr && addr == 32'h50020644 && !analog_mode[0] ##1 !wr && !analog_mode[0];
  endsequence
  a_wr_drive: assert property (s_wr0 |=>
    pad_out_en_r[0] == ($past(wdata[9:8], 2) == 2'h3))
    else $error("output enable does not follow code");
  a_wr_pull: assert property (s_wr0 |=>
    {pad_pull_up_r[0], pad_pull_down_r[0]} == {$past(wdata[9:8], 2) == 2'h1,
    $past(wdata[9:8], 2) == 2'h2})
    else $error("pull enables do not follow code");
  a_wr_odrain: assert property (s_wr0 |=>
    pad_open_drain_r[0] == $past(wdata[10], 2))
    else $error("drive type does not follow bit 10");
  a_out_nopull: assert property ((pad_out_en_r & pulls) == 0)
    else $error("pull on while driving");
  a_rd_resvd: assert property (rdata_r[7:6] == 2'h0 && rdata_r[31:11] == 0)
    else $error("reserved read bits set");
  // three cycles of analog so the decode flop has caught up
  a_analog_off: assert property (((pad_out_en_r | pulls) & analog_mode
    & $past(analog_mode) & $past(analog_mode, 2)) == 0)
    else $error("digital pad active in analog mode");
endmodule // pmcb_chk

bind pmcb_bank pmcb_chk #(.NPAD(NPAD)) u_chk (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rdata_r(rdata_r),
  .analog_mode(analog_mode), .pad_out_en_r(pad_out_en_r),
  .pad_pull_up_r(pad_pull_up_r), .pad_pull_down_r(pad_pull_down_r),
  .pad_open_drain_r(pad_open_drain_r));

// *** pad_mode_config_bank_tb_top.sv ***
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module pad_mode_config_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, wr = 0, rd = 0;
  logic [31:0] addr = 0, wdata = 0, rdata_r;
  logic [6:0]  am = 0, oe, ie, pu, pd, od;
  logic [41:0] fn;
  int          n_fail = 0, checked = 0, cyc = 0;
  pmcb_bank dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_r(rdata_r), .analog_mode(am), .pad_out_en_r(oe),
    .pad_in_en_r(ie), .pad_pull_up_r(pu), .pad_pull_down_r(pd),
    .pad_open_drain_r(od), .pad_func_r(fn));
  // clock
  initial forever #5 clk = ~clk;
  // hang guard, far above the some 60 cycles needed
  always @(posedge clk)
    if (++cyc == 3000)
    begin
      n_fail++;
      results();
    end
  // verdict
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr_t(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read, data checked in the answer cycle only
  task automatic rd_t(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata_r)
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_t(32'h50020644 + 4 * i, 32'h200);
    `CHK("pd", 7'h7f, pd)
    // every code; reserved and high bits written as ones
    for (int i = 0; i < 7; i++)
    begin
      wr_t(32'h50020644 + 4 * i, 32'hfffff8c0 | (i % 4) << 8 | i[0] << 10 | i);
      rd_t(32'h50020644 + 4 * i, (i % 4) << 8 | i[0] << 10 | i);
      `CHK("oe", i % 4 == 3, oe[i])
      `CHK("pu", i % 4 == 1, pu[i])
      `CHK("pd", i % 4 == 2, pd[i])
      `CHK("od", i[0], od[i])
      `CHK("ie", i % 4 != 3, ie[i])
      `CHK("fn", i[5:0], fn[6 * i +: 6])
    end
    // misaligned write ignored, unmapped read gives zero
    wr_t(32'h50020646, 32'h300);
    rd_t(32'h50020644, 32'h0);
    rd_t(32'h50020660, 32'h0);
    // analog pad keeps its field but drives nothing
    @(posedge clk) am <= 7'h08;
    wr_t(32'h50020650, 32'h100);
    rd_t(32'h50020650, 32'h100);
    `CHK("oe", 1'b0, oe[3])
    `CHK("pu", 1'b0, pu[3])
    `CHK("pd", 1'b0, pd[3])
    `CHK("ie", 1'b0, ie[3])
    @(posedge clk) am <= 7'h00;
    rd_t(32'h50020650, 32'h100);
    `CHK("pu", 1'b1, pu[3])
    results();
  end
endmodule // pad_mode_config_bank_tb_top
